// ### src/hbpwm_defines.svh
// Purpose: Timing constants of the half-bridge PWM sequencer.
// Assumes: A 40 MHz device clock.
// Notes: Times are in ns; cycle counts derive from them.
`ifndef HBPWM_DEFINES_SVH
`define HBPWM_DEFINES_SVH
`define HBPWM_CLK_NS 25
`define HBPWM_OSC_NS 2500
`define HBPWM_OSC_CYC (`HBPWM_OSC_NS / `HBPWM_CLK_NS)
`define HBPWM_TCLK_NS 65
`define HBPWM_TCLK_CYC ((`HBPWM_TCLK_NS + `HBPWM_CLK_NS - 1) / `HBPWM_CLK_NS)
`define HBPWM_NS_PER_SET 2
`define HBPWM_TD_OFS_NS 20
`define HBPWM_TD_MIN_NS 30
`define HBPWM_T2_OFS_NS 30
`endif

// ### src/hbpwm_pkg.sv
// Purpose: Types shared by the half-bridge PWM sequencer files.
// Assumes: Nothing beyond the defines header.
// Notes: Comparator levels arrive as one packed group.
package hbpwm_pkg;
	typedef struct packed {
		logic ramp_trip;
		logic vin_above_aux_undervoltage_lockout_input;
		logic bias_ok;
		logic ref_ok;
		logic undervoltage_lockout_input_above_thr;
		logic ss_above_secen;
		logic control_above_offset;
		logic comp_below_en;
		logic rect_ss_above_en;
	} hbpwm_cmp_s;
	typedef struct packed {
		logic low_side_gate_drive;
		logic high_side_gate_drive;
		logic rectifier_drive_a;
		logic rectifier_drive_b;
	} hbpwm_drv_s;
	typedef struct packed {
		logic aux_enable;
		logic aux_on_state;
		logic pri_ss_charge;
		logic rect_ss_charge;
	} hbpwm_sup_s;
	typedef enum logic [2:0] {
		PS_IDLE = 3'b000,
		PS_WAIT = 3'b001,
		PS_ON = 3'b010,
		PS_DEAD = 3'b011,
		PS_FREE = 3'b100
	} hbpwm_ps_e;
	typedef enum logic [1:0] {
		SU_OFF = 2'b00,
		SU_PRI = 2'b01,
		SU_SR = 2'b10
	} hbpwm_su_e;
endpackage

// ### src/hbpwm_delay.sv
// Purpose: Programmable delay, one pulse after a time given in ns.
// Assumes: target_ns stays steady while a delay runs.
// Notes: Rounds up to whole cycles, plus one register stage.
`timescale 1ns/100ps
module hbpwm_delay #(
	parameter int STEP_NS = 25,
	parameter int TW = 10
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Request
	input wire logic start,
	input wire logic [TW-1:0] target_ns,
	// Answer
	output logic done
);
	localparam int AW = TW + 1;
	logic active_q;
	logic done_q;
	logic [AW-1:0] acc_q;
	wire reached = acc_q >= {1'b0, target_ns};

	if (STEP_NS < 1 || STEP_NS >= (1 << TW)) begin : g_chk
		$error("Step must be positive.");
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			active_q <= 1'b0;
			done_q <= 1'b0;
			acc_q <= '0;
		end else begin
			done_q <= active_q && reached && !start;
			if (start) begin
				active_q <= 1'b1;
				acc_q <= AW'(STEP_NS);
			end else if (active_q) begin
				if (reached) begin
					active_q <= 1'b0;
				end else begin
					acc_q <= acc_q + AW'(STEP_NS);
				end
			end
		end
	end

	assign done = done_q;
endmodule

// ### src/hbpwm_top.sv
// Purpose: Half-bridge PWM sequencer with pre-biased start-up.
// Assumes: Analog comparators deliver single-bit levels.
// Notes: Delay settings are static straps in kOhm units.
//
// Operation
// RULE1: Main clock rise switches both rectifier drives off.
// RULE2: Active primary gate turns on at delayed clock fall.
// RULE3: Delayed clock lags by setting times 2 ns plus 20 ns, at least 30.
// RULE4: Clock pulse is 65 ns; first dead-time is delay plus pulse.
// RULE5: Primary ends on ramp trip or next delayed clock rise.
// RULE6: Second dead-time is setting times 2 ns plus 30 ns.
// RULE7: While low side is on, drive B on and drive A off.
// RULE8: Freewheeling holds both primaries off and both rectifiers on.
// RULE9: B off before high side; both back on after second dead-time.
// RULE10: Phases: low transfer, freewheel, high transfer, freewheel.
// RULE11: At maximum duty the clock pulse is the cross-conduction gap.
// RULE12: Start-up runs primary soft-start, then rectifier soft-start.
// RULE13: Auxiliary enabled when input, bias and reference are all valid.
// RULE14: Primary soft-start charges when lockout input, bias, reference valid.
// RULE15: Auxiliary at off level until soft-start reaches its threshold.
// RULE16: Secondary holds its reference discharged while off level seen.
// RULE17: Duty rises only once control exceeds the soft-start offset.
// RULE18: Rectifier soft-start charges once control current drops low.
// RULE19: Smaller of control and soft-start, scaled, feeds duty comparator.
// RULE20: Below rectifier enable level, rectifiers follow their primary pulse.
// RULE21: Analog comparisons arrive as synchronized single-bit inputs.
`timescale 1ns/100ps
`include "hbpwm_defines.svh"
module hbpwm_top #(
	parameter int OSC_CYC = `HBPWM_OSC_CYC,
	parameter int SET_W = 8
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Comparator levels from the analog front end
	input wire hbpwm_pkg::hbpwm_cmp_s cmp_in,
	// Delay settings
	input wire logic [SET_W-1:0] first_delay_setting,
	input wire logic [SET_W-1:0] second_delay_setting,
	// Gate and rectifier drives
	output hbpwm_pkg::hbpwm_drv_s drive,
	// Supply sequencing
	output hbpwm_pkg::hbpwm_sup_s supply
);
	localparam int TCLK_CYC = `HBPWM_TCLK_CYC;
	localparam int OW = $clog2(OSC_CYC);
	localparam int CW = $clog2(TCLK_CYC + 1);
	localparam int TW = SET_W + 2;

	if (OSC_CYC < 4 * TCLK_CYC || TCLK_CYC < 2) begin : g_chk
		$error("Oscillator period too short for the clock pulse.");
	end

	// ----------------------------------------------------------------
	// Input synchronizers
	// ----------------------------------------------------------------
	hbpwm_pkg::hbpwm_cmp_s meta_q;
	hbpwm_pkg::hbpwm_cmp_s cmp;
	logic [SET_W-1:0] first_meta_q;
	logic [SET_W-1:0] first_set_q;
	logic [SET_W-1:0] second_meta_q;
	logic [SET_W-1:0] second_set_q;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			meta_q <= '0;
			cmp <= '0;
			first_meta_q <= '0;
			first_set_q <= '0;
			second_meta_q <= '0;
			second_set_q <= '0;
		end else begin
			meta_q <= cmp_in;
			cmp <= meta_q; // RULE21
			first_meta_q <= first_delay_setting;
			first_set_q <= first_meta_q;
			second_meta_q <= second_delay_setting;
			second_set_q <= second_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Start-up sequencing
	// ----------------------------------------------------------------
	hbpwm_pkg::hbpwm_su_e su_q;
	hbpwm_pkg::hbpwm_su_e su_d;
	logic aux_en_q;
	logic aux_on_q;
	logic pri_ss_q;
	logic rect_ss_q;
	wire rails_ok = cmp.bias_ok && cmp.ref_ok;
	wire aux_en_d = cmp.vin_above_aux_undervoltage_lockout_input && rails_ok; // RULE13
	wire ss_cond = cmp.undervoltage_lockout_input_above_thr && rails_ok; // RULE14
	wire running = su_q != hbpwm_pkg::SU_OFF;
	wire aux_on_d = aux_en_d && ss_cond && running && cmp.ss_above_secen; // RULE15
	wire sync_mode = !(su_q == hbpwm_pkg::SU_SR && cmp.rect_ss_above_en); // RULE20

	always_comb begin
		su_d = su_q;
		unique case (su_q)
			hbpwm_pkg::SU_OFF: begin
				su_d = hbpwm_pkg::SU_PRI; // RULE14
			end
			hbpwm_pkg::SU_PRI: begin
				if (aux_on_q && cmp.comp_below_en) begin
					su_d = hbpwm_pkg::SU_SR; // RULE12 RULE18
				end
			end
			hbpwm_pkg::SU_SR: begin
				su_d = hbpwm_pkg::SU_SR;
			end
			default: begin
				su_d = hbpwm_pkg::SU_OFF;
			end
		endcase
		if (!ss_cond) begin
			su_d = hbpwm_pkg::SU_OFF;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			su_q <= hbpwm_pkg::SU_OFF;
			aux_en_q <= 1'b0;
			aux_on_q <= 1'b0;
			pri_ss_q <= 1'b0;
			rect_ss_q <= 1'b0;
		end else begin
			su_q <= su_d;
			aux_en_q <= aux_en_d;
			aux_on_q <= aux_on_d;
			pri_ss_q <= su_d != hbpwm_pkg::SU_OFF; // RULE14
			rect_ss_q <= su_d == hbpwm_pkg::SU_SR; // RULE18
		end
	end

	// ----------------------------------------------------------------
	// Main and delayed clocks
	// ----------------------------------------------------------------
	logic [OW-1:0] osc_q;
	logic [CW-1:0] dclk_q;
	logic td_done;
	logic t2_done;
	logic t2_start;
	wire main_rise = osc_q == '0;
	wire dclk_rise = td_done;
	wire dclk_fall = dclk_q == CW'(1);
	wire [TW-1:0] td_raw = TW'(`HBPWM_NS_PER_SET * int'(first_set_q) + `HBPWM_TD_OFS_NS);
	wire [TW-1:0] td_ns = (td_raw < TW'(`HBPWM_TD_MIN_NS)) ? TW'(`HBPWM_TD_MIN_NS) : td_raw; // RULE3
	wire [TW-1:0] t2_ns = TW'(`HBPWM_NS_PER_SET * int'(second_set_q) + `HBPWM_T2_OFS_NS); // RULE6

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			osc_q <= '0;
			dclk_q <= '0;
		end else begin
			osc_q <= (osc_q == OW'(OSC_CYC - 1)) ? '0 : osc_q + OW'(1);
			if (dclk_rise) begin
				dclk_q <= CW'(TCLK_CYC); // RULE4
			end else if (dclk_q != '0) begin
				dclk_q <= dclk_q - CW'(1);
			end
		end
	end

	// A delayed clock rise while a previous pulse is still high restarts it.
	hbpwm_delay #(
		.STEP_NS(`HBPWM_CLK_NS),
		.TW(TW)
	) u_td (
		.clock(clock),
		.rstn(rstn),
		.start(main_rise),
		.target_ns(td_ns),
		.done(td_done)
	);

	hbpwm_delay #(
		.STEP_NS(`HBPWM_CLK_NS),
		.TW(TW)
	) u_t2 (
		.clock(clock),
		.rstn(rstn),
		.start(t2_start),
		.target_ns(t2_ns),
		.done(t2_done)
	);

	// ----------------------------------------------------------------
	// Drive sequencer
	// ----------------------------------------------------------------
	hbpwm_pkg::hbpwm_ps_e ps_q;
	hbpwm_pkg::hbpwm_ps_e ps_d;
	logic [1:0] pri_q;
	logic [1:0] pri_d;
	logic [1:0] rect_q;
	logic [1:0] rect_d;
	logic side_q;
	logic side_d;
	logic arm_q;
	logic arm_d;
	// The ramp comparator already sees the smaller of control and soft-start.
	wire pri_end = cmp.ramp_trip || dclk_rise; // RULE5 RULE11 RULE19
	wire duty_ok = cmp.control_above_offset; // RULE17
	wire [1:0] pri_side = side_q ? 2'b10 : 2'b01;
	wire [1:0] rect_side = side_q ? 2'b01 : 2'b10; // RULE7 RULE9

	always_comb begin
		ps_d = ps_q;
		pri_d = pri_q;
		rect_d = rect_q;
		side_d = side_q;
		arm_d = arm_q;
		t2_start = 1'b0;
		unique case (ps_q)
			hbpwm_pkg::PS_ON: begin
				if (pri_end) begin
					ps_d = hbpwm_pkg::PS_DEAD;
					pri_d = 2'b00;
					t2_start = 1'b1; // RULE6
					if (sync_mode) begin
						rect_d = 2'b00; // RULE20
					end
				end
			end
			hbpwm_pkg::PS_DEAD: begin
				if (t2_done) begin
					ps_d = hbpwm_pkg::PS_FREE; // RULE10
					if (!sync_mode && !arm_q) begin
						rect_d = 2'b11; // RULE8 RULE9
					end
				end
			end
			hbpwm_pkg::PS_IDLE, hbpwm_pkg::PS_WAIT, hbpwm_pkg::PS_FREE: begin
				ps_d = ps_q;
			end
			default: begin
				ps_d = hbpwm_pkg::PS_IDLE;
			end
		endcase
		if (main_rise) begin
			rect_d = 2'b00; // RULE1
			arm_d = 1'b1;
			if (ps_q != hbpwm_pkg::PS_ON) begin
				ps_d = hbpwm_pkg::PS_WAIT;
			end
		end
		if (dclk_fall && arm_q && ps_q != hbpwm_pkg::PS_ON) begin
			arm_d = 1'b0;
			side_d = !side_q; // RULE10
			ps_d = hbpwm_pkg::PS_WAIT;
			if (duty_ok) begin
				ps_d = hbpwm_pkg::PS_ON;
				pri_d = pri_side; // RULE2
				rect_d = rect_side; // RULE7
			end
		end
		if (!running) begin
			ps_d = hbpwm_pkg::PS_IDLE;
			pri_d = 2'b00;
			rect_d = 2'b00;
			side_d = 1'b0;
			arm_d = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ps_q <= hbpwm_pkg::PS_IDLE;
			pri_q <= 2'b00;
			rect_q <= 2'b00;
			side_q <= 1'b0;
			arm_q <= 1'b0;
		end else begin
			ps_q <= ps_d;
			pri_q <= pri_d;
			rect_q <= rect_d;
			side_q <= side_d;
			arm_q <= arm_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign drive.low_side_gate_drive = pri_q[0];
	assign drive.high_side_gate_drive = pri_q[1];
	assign drive.rectifier_drive_a = rect_q[0];
	assign drive.rectifier_drive_b = rect_q[1];
	assign supply.aux_enable = aux_en_q;
	assign supply.aux_on_state = aux_on_q;
	assign supply.pri_ss_charge = pri_ss_q;
	assign supply.rect_ss_charge = rect_ss_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	wire pri_any = pri_q != 2'b00;
	wire rect_both = rect_q == 2'b11;

	sequence s_dclk_pulse;
		(dclk_q != '0) [*3] ##1 (dclk_q == '0);
	endsequence

	sequence s_no_free_2;
		!rect_both ##1 !rect_both;
	endsequence

	AST_RECT_OFF_MAIN: assert property (@(posedge clock) disable iff (!rstn) // RULE1
		main_rise |=> rect_q == 2'b00) else $error("Rectifiers not off after main clock rise.");
	AST_PRI_ON_DCLK: assert property (@(posedge clock) disable iff (!rstn) // RULE2
		$rose(pri_any) |-> $past(dclk_fall)) else $error("Primary turned on away from delayed clock fall.");
	AST_TD_MIN: assert property (@(posedge clock) disable iff (!rstn) // RULE3
		main_rise |=> !dclk_rise ##1 !dclk_rise) else $error("Delayed clock came too early.");
	AST_DCLK_WIDTH: assert property (@(posedge clock) disable iff (!rstn) // RULE4
		dclk_rise && dclk_q == '0 |=> s_dclk_pulse) else $error("Clock pulse width wrong.");
	AST_PRI_END: assert property (@(posedge clock) disable iff (!rstn) // RULE5
		ps_q == hbpwm_pkg::PS_ON && pri_end |=> !pri_any) else $error("Primary pulse did not end.");
	AST_T2_GAP: assert property (@(posedge clock) disable iff (!rstn) // RULE6
		$fell(pri_any) |-> s_no_free_2) else $error("Second dead-time too short.");
	AST_LOW_RECT: assert property (@(posedge clock) disable iff (!rstn) // RULE7
		$rose(drive.low_side_gate_drive) |-> rect_q == 2'b10) else $error("Low side with wrong rectifiers.");
	AST_FREEWHEEL: assert property (@(posedge clock) disable iff (!rstn) // RULE8
		rect_both |-> !pri_any && ps_q == hbpwm_pkg::PS_FREE) else $error("Freewheel with primary on.");
	AST_HIGH_RECT: assert property (@(posedge clock) disable iff (!rstn) // RULE9
		drive.high_side_gate_drive |-> !drive.rectifier_drive_b) else $error("Drive B on with high side.");
	AST_SS_ORDER: assert property (@(posedge clock) disable iff (!rstn) // RULE12
		$rose(supply.rect_ss_charge) |-> $past(running) && $past(aux_on_q)) else $error("Start-up order broken.");
	AST_AUX_ON: assert property (@(posedge clock) disable iff (!rstn) // RULE15
		aux_on_q |-> aux_en_q && running) else $error("Auxiliary on-state without enable.");
	AST_ZERO_DUTY: assert property (@(posedge clock) disable iff (!rstn) // RULE17
		$rose(pri_any) |-> $past(duty_ok)) else $error("Duty rose below the offset.");
	AST_SYNC_MODE: assert property (@(posedge clock) disable iff (!rstn) // RULE20
		rect_q != 2'b00 && sync_mode |-> pri_any || $past(pri_any)) else $error("Rectifier pulse outside primary.");
endmodule

// ### sim/hbpwm_far_model.sv
// Purpose: Far side of the sequencer: power stage ramp and secondary reference.
// Assumes: Drives are active-high levels.
// Notes: A trip delay of zero never trips, which gives maximum duty.
`timescale 1ns/100ps
module hbpwm_far_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Device outputs
	input wire hbpwm_pkg::hbpwm_drv_s drive,
	input wire hbpwm_pkg::hbpwm_sup_s supply,
	// Ramp control
	input wire logic [7:0] trip_delay,
	// Answers
	output logic ramp_trip_q,
	output logic ref_released,
	output logic overlap_q
);
	logic [7:0] ramp_q;
	wire pri_on = drive.low_side_gate_drive | drive.high_side_gate_drive;
	// The secondary reference stays discharged until the on-state level shows.
	assign ref_released = supply.aux_on_state;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ramp_q <= 8'h00;
			ramp_trip_q <= 1'b0;
			overlap_q <= 1'b0;
		end else begin
			ramp_q <= pri_on ? ramp_q + 8'h01 : 8'h00;
			ramp_trip_q <= pri_on && trip_delay != 8'h00 && ramp_q >= trip_delay;
			overlap_q <= overlap_q | (drive.low_side_gate_drive & drive.high_side_gate_drive);
		end
	end
endmodule

// ### sim/hbpwm_top_test.sv
// Purpose: Self-checking bench for the half-bridge PWM sequencer.
// Assumes: A short oscillator period of 20 cycles; delay settings change only inside the delay-settings test.
// Notes: Observed bits, MSB first: low, high, rect a, rect b, then the four supply flags.
`timescale 1ns/100ps
module hbpwm_top_test;
	localparam int TD_CYC = (2 * 5 + 20 + 24) / 25 + 1;
	localparam int TCLK_CYC = (65 + 24) / 25;
	localparam int T2_CYC = (30 + 24) / 25 + 1;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	hbpwm_pkg::hbpwm_cmp_s cmp = '0;
	logic [7:0] trip_delay = 8'h04;
	logic [7:0] first_set = 8'h05;
	logic [7:0] second_set = 8'h00;
	hbpwm_pkg::hbpwm_drv_s drive_w;
	hbpwm_pkg::hbpwm_sup_s supply_w;
	logic trip_w;
	logic ref_w;
	logic overlap_w;
	wire hbpwm_pkg::hbpwm_cmp_s cmp_w = {trip_w, cmp[7:0]};
	wire [7:0] obs = {drive_w, supply_w};
	int err_count = 0;
	int tests_run = 0;
	int n;
	always #12.5 clock = ~clock;
	hbpwm_top #(.OSC_CYC(20), .SET_W(8)) dut_u (.clock(clock), .rstn(rstn), .cmp_in(cmp_w),
		.first_delay_setting(first_set), .second_delay_setting(second_set), .drive(drive_w), .supply(supply_w));
	hbpwm_far_model far_u (.clock(clock), .rstn(rstn), .drive(drive_w), .supply(supply_w),
		.trip_delay(trip_delay), .ramp_trip_q(trip_w), .ref_released(ref_w), .overlap_q(overlap_w));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task cyc(input int k);
		repeat (k) @(posedge clock);
		#2;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// A bounded wait keeps a stuck output from hanging the run.
	task wait_obs(input logic [7:0] mask, input logic [7:0] val, output int k);
		k = 0;
		while ((obs & mask) !== val && k < 200) begin
			cyc(1);
			k++;
		end
		chk({7'h00, k < 200}, 8'h01);
	endtask
	task end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_startup;
		chk(obs, 8'h00);
		{cmp.vin_above_aux_undervoltage_lockout_input, cmp.bias_ok, cmp.ref_ok} = 3'h7;
		wait_obs(8'h08, 8'h08, n);
		chk({7'h00, n <= 4}, 8'h01);
		cyc(6);
		chk({6'h00, obs[1:0]}, 8'h00);
		cmp.undervoltage_lockout_input_above_thr = 1'b1;
		wait_obs(8'h02, 8'h02, n);
		chk({7'h00, n <= 4}, 8'h01);
		chk({6'h00, obs[2], ref_w}, 8'h00);
		cmp.ss_above_secen = 1'b1;
		wait_obs(8'h04, 8'h04, n);
		chk({6'h00, ref_w, obs[0]}, 8'h02);
		n = 0;
		repeat (60) begin
			cyc(1);
			n += (obs[7:6] != 2'h0);
		end
		chk(8'(n), 8'h00);
		$display("test startup done");
	endtask
	task t_sync;
		cmp.control_above_offset = 1'b1;
		cmp.comp_below_en = 1'b1;
		wait_obs(8'h01, 8'h01, n);
		chk({7'h00, n <= 4}, 8'h01);
		wait_obs(8'h80, 8'h80, n);
		chk({4'h0, obs[7:4]}, 8'h09);
		wait_obs(8'h80, 8'h00, n);
		chk({4'h0, obs[7:4]}, 8'h00);
		cyc(T2_CYC + 3);
		chk({4'h0, obs[7:4]}, 8'h00);
		$display("test sync done");
	endtask
	task t_comp;
		cmp.rect_ss_above_en = 1'b1;
		cyc(45);
		wait_obs(8'h80, 8'h80, n);
		wait_obs(8'h80, 8'h00, n);
		wait_obs(8'h30, 8'h30, n);
		chk({7'h00, n >= T2_CYC && n <= T2_CYC + 2}, 8'h01);
		chk({6'h00, obs[7:6]}, 8'h00);
		wait_obs(8'h30, 8'h00, n);
		wait_obs(8'h40, 8'h40, n);
		chk(8'(n), 8'(TD_CYC + TCLK_CYC));
		chk({4'h0, obs[7:4]}, 8'h06);
		wait_obs(8'h80, 8'h80, n);
		chk({4'h0, obs[7:4]}, 8'h09);
		$display("test complementary done");
	endtask
	task t_delay;
		first_set = 8'h00;
		second_set = 8'h14;
		cyc(45);
		wait_obs(8'h80, 8'h80, n);
		wait_obs(8'h80, 8'h00, n);
		wait_obs(8'h30, 8'h30, n);
		chk({7'h00, n >= 4 && n <= 6}, 8'h01);
		wait_obs(8'h30, 8'h00, n);
		wait_obs(8'h40, 8'h40, n);
		chk(8'(n), 8'h06);
		first_set = 8'h10;
		cyc(45);
		wait_obs(8'h80, 8'h80, n);
		wait_obs(8'h80, 8'h00, n);
		wait_obs(8'h30, 8'h00, n);
		wait_obs(8'h40, 8'h40, n);
		chk(8'(n), 8'h07);
		first_set = 8'h05;
		second_set = 8'h00;
		$display("test delay settings done");
	endtask
	task t_maxduty;
		trip_delay = 8'h00;
		cyc(45);
		wait_obs(8'h80, 8'h80, n);
		wait_obs(8'h80, 8'h00, n);
		wait_obs(8'h40, 8'h40, n);
		chk(8'(n), 8'(TCLK_CYC));
		chk({7'h00, overlap_w}, 8'h00);
		$display("test maximum duty done");
	endtask
	task t_fail;
		cmp.undervoltage_lockout_input_above_thr = 1'b0;
		wait_obs(8'h06, 8'h00, n);
		chk({7'h00, n <= 3 && obs[3]}, 8'h01);
		cyc(1);
		chk({4'h0, obs[7:4]}, 8'h00);
		cmp.bias_ok = 1'b0;
		wait_obs(8'h0F, 8'h00, n);
		chk({7'h00, n <= 4}, 8'h01);
		$display("test supply loss done");
	endtask
	initial begin
		cyc(12);
		rstn = 1'b1;
		cyc(1);
		t_startup();
		t_sync();
		t_comp();
		t_delay();
		t_maxduty();
		t_fail();
		end_of_test();
	end
	initial begin
		repeat (3000) @(posedge clock);
		err_count++;
		end_of_test();
	end
endmodule
